// [pfc_pause_ctrl.v]
// pause flow-control logic with its control/status registers on axi4-lite
`timescale 1ns/100ps
`include "pfc_defines.vh"
module pfc_pause_ctrl (
    input  wire        i_mclk,
    input  wire        i_resetn,
    input  wire        i_speed_100,
    input  wire        i_adv_pause_cap,
    input  wire        i_an_pause_ok,
    input  wire        i_rx_pause_valid,
    input  wire [47:0] i_rx_pause_dest,
    input  wire        i_rx_perfect_hit,
    input  wire        i_rx_pattern_hit,
    input  wire [15:0] i_rx_pause_len,
    output wire        o_tx_hold,
    output wire        o_irq,
    input  wire [7:0]  i_awaddr,
    input  wire        i_awvalid,
    output wire        o_awready,
    input  wire [31:0] i_wdata,
    input  wire [3:0]  i_wstrb,
    input  wire        i_wvalid,
    output wire        o_wready,
    output reg  [1:0]  o_bresp,
    output reg         o_bvalid,
    input  wire        i_bready,
    input  wire [7:0]  i_araddr,
    input  wire        i_arvalid,
    output wire        o_arready,
    output reg  [31:0] o_rdata,
    output reg  [1:0]  o_rresp,
    output reg         o_rvalid,
    input  wire        i_rready
);
    localparam [11:0] SLOT_10M  = `PFC_SLOT_CYC_10M;
    localparam [11:0] SLOT_100M = `PFC_SLOT_CYC_100M;

    // control bits and pause state
    reg         manual_en_q;
    reg         group_addr_q;
    reg         dest_match_q;
    reg  [15:0] count_q;
    reg         seen_q;
    reg  [11:0] slot_cnt_q;
    reg  [1:0]  irq_stat_q;
    reg  [1:0]  irq_mask_q;
    // the status line is a strap-like level from the phy domain, so it is synchronised
    reg  [1:0]  an_sync_q;
    reg  [1:0]  adv_sync_q;

    // write address/data are held separately so either may arrive first
    reg         aw_hold_q;
    reg  [7:0]  aw_addr_q;
    reg         w_hold_q;
    reg  [31:0] w_data_q;
    reg  [3:0]  w_strb_q;

    wire autoneg_ok = an_sync_q[1] & adv_sync_q[1];
    wire rx_enable  = manual_en_q | autoneg_ok;
    wire active     = (count_q != 16'h0000);
    wire group_hit  = group_addr_q & (i_rx_pause_dest == `PFC_GROUP_ADDR);
    wire rx_filter_hit = i_rx_perfect_hit | i_rx_pattern_hit;
    wire dest_hit   = dest_match_q & rx_filter_hit;
    wire rx_accept  = i_rx_pause_valid & rx_enable & (group_hit | dest_hit);
    wire [11:0] slot_len = i_speed_100 ? SLOT_100M : SLOT_10M;
    wire slot_tick  = active & (slot_cnt_q == slot_len - 12'h001);

    assign o_tx_hold = active;
    assign o_irq     = |(irq_stat_q & irq_mask_q);

    // write channel: take address and data independently, answer when both held
    assign o_awready = ~aw_hold_q & ~o_bvalid;
    assign o_wready  = ~w_hold_q & ~o_bvalid;
    wire wr_go = aw_hold_q & w_hold_q & ~o_bvalid;

    function [31:0] merge;
        input [31:0] old_v;
        input [31:0] new_v;
        input [3:0]  strb;
        integer k;
        begin
            for (k = 0; k < 4; k = k + 1) begin
                merge[k*8 +: 8] = strb[k] ? new_v[k*8 +: 8] : old_v[k*8 +: 8];
            end
        end
    endfunction

    wire [31:0] ctrl_view = {manual_en_q, group_addr_q, dest_match_q, 5'h00,
                             active, seen_q, autoneg_ok, 5'h00, count_q};
    wire [31:0] ctrl_wr   = merge(ctrl_view & 32'hffff0000 | {16'h0000, count_q}, w_data_q, w_strb_q);
    // register select codes shared by the write and read paths
    localparam [1:0] SEL_NONE = 2'h0;
    localparam [1:0] SEL_CTRL = 2'h1;
    localparam [1:0] SEL_STAT = 2'h2;
    localparam [1:0] SEL_MASK = 2'h3;

    // low two address bits are ignored: every register is one aligned word
    function [1:0] reg_decode;
        input [7:0] addr;
        begin
            case ({addr[7:2], 2'b00})
                `PFC_OFF_CTRL:       reg_decode = SEL_CTRL;
                `PFC_OFF_IRQ_STATUS: reg_decode = SEL_STAT;
                `PFC_OFF_IRQ_MASK:   reg_decode = SEL_MASK;
                default:             reg_decode = SEL_NONE;
            endcase
        end
    endfunction

    wire [1:0] wr_sel = reg_decode(aw_addr_q);
    wire [1:0] rd_sel = reg_decode(i_araddr);
    wire wr_ctrl  = wr_go & (wr_sel == SEL_CTRL);
    wire wr_stat  = wr_go & (wr_sel == SEL_STAT);
    wire wr_mask  = wr_go & (wr_sel == SEL_MASK);
    wire ld_req   = wr_ctrl & w_strb_q[2] & w_data_q[`PFC_BIT_LOAD];
    wire ld_ok    = ld_req & ~seen_q & ~active;
    wire man_off  = wr_ctrl & w_strb_q[3] & manual_en_q & ~ctrl_wr[`PFC_BIT_MANUAL_EN];
    wire end_now  = man_off & ~autoneg_ok;
    wire int_end  = active & ((slot_tick & (count_q == 16'h0001)) | end_now);

    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            an_sync_q  <= 2'b00;
            adv_sync_q <= 2'b00;
        end else begin
            an_sync_q  <= {an_sync_q[0], i_an_pause_ok};
            adv_sync_q <= {adv_sync_q[0], i_adv_pause_cap};
        end
    end

    // pause counter and status
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            count_q    <= 16'h0000;
            seen_q     <= 1'b0;
            slot_cnt_q <= 12'h000;
        end else if (end_now) begin
            count_q    <= 16'h0000;
            seen_q     <= 1'b0;
            slot_cnt_q <= 12'h000;
        end else if (rx_accept) begin
            count_q    <= i_rx_pause_len;
            seen_q     <= (i_rx_pause_len != 16'h0000);
            slot_cnt_q <= 12'h000;
        end else if (ld_ok) begin
            count_q    <= ctrl_wr[15:0];
            slot_cnt_q <= 12'h000;
        end else if (active) begin
            if (slot_tick) begin
                slot_cnt_q <= 12'h000;
                count_q    <= count_q - 16'h0001;
                if (count_q == 16'h0001) begin
                    seen_q <= 1'b0;
                end
            end else begin
                slot_cnt_q <= slot_cnt_q + 12'h001;
            end
        end
    end

    // write address capture; the hold flag closes the channel until the response is out
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
        end else if (wr_go) begin
            aw_hold_q <= 1'b0;
        end else if (i_awvalid & o_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= {i_awaddr[7:2], 2'b00};
        end
    end

    // write data capture
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            w_hold_q <= 1'b0;
            w_data_q <= 32'h00000000;
            w_strb_q <= 4'h0;
        end else if (wr_go) begin
            w_hold_q <= 1'b0;
        end else if (i_wvalid & o_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
        end
    end

    // write response: unmapped words answer slverr and change nothing
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bvalid <= 1'b0;
            o_bresp  <= `PFC_RESP_OKAY;
        end else if (wr_go) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (wr_sel != SEL_NONE) ? `PFC_RESP_OKAY : `PFC_RESP_SLVERR;
        end else if (o_bvalid & i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // control bits of the pause register
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            manual_en_q  <= 1'b0;
            group_addr_q <= 1'b0;
            dest_match_q <= 1'b0;
        end else if (wr_ctrl) begin
            manual_en_q  <= ctrl_wr[`PFC_BIT_MANUAL_EN];
            group_addr_q <= ctrl_wr[`PFC_BIT_GROUP_ADDR];
            dest_match_q <= ctrl_wr[`PFC_BIT_DEST_MATCH];
        end
    end

    // interrupt mask
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_mask_q <= 2'b00;
        end else if (wr_mask & w_strb_q[0]) begin
            irq_mask_q <= w_data_q[1:0];
        end
    end

    // interrupt status, write one to clear
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_stat_q <= 2'b00;
        end else begin
            // a new event in the clearing cycle wins over the clear
            irq_stat_q <= (irq_stat_q & ~((wr_stat & w_strb_q[0]) ? w_data_q[1:0] : 2'b00))
                          | {int_end, rx_accept};
        end
    end

    // read channel: data is captured at the address edge, so a read shows the live counter then
    always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_rvalid <= 1'b0;
            o_rresp  <= `PFC_RESP_OKAY;
            o_rdata  <= 32'h00000000;
        end else if (i_arvalid & o_arready) begin
            o_rvalid <= 1'b1;
            o_rresp  <= `PFC_RESP_OKAY;
            case (rd_sel)
                SEL_CTRL: o_rdata <= ctrl_view;
                SEL_STAT: o_rdata <= {30'h00000000, irq_stat_q};
                SEL_MASK: o_rdata <= {30'h00000000, irq_mask_q};
                default: begin
                    o_rdata <= 32'h00000000;
                    o_rresp <= `PFC_RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid & i_rready) begin
            o_rvalid <= 1'b0;
        end
    end

    assign o_arready = ~o_rvalid;
endmodule // pfc_pause_ctrl

// [pfc_defines.vh]
// constants for the pause flow-control block
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH
`define PFC_ADDR_W            8
`define PFC_OFF_CTRL          8'h44
`define PFC_OFF_IRQ_STATUS    8'h48
`define PFC_OFF_IRQ_MASK      8'h4c
`define PFC_CTRL_RESET        32'h00000000
`define PFC_BIT_MANUAL_EN     31
`define PFC_BIT_GROUP_ADDR    30
`define PFC_BIT_DEST_MATCH    29
`define PFC_BIT_ACTIVE        23
`define PFC_BIT_SEEN          22
`define PFC_BIT_AUTONEG       21
`define PFC_BIT_LOAD          16
`define PFC_GROUP_ADDR        48'h0180c2000001
`define PFC_SLOT_BITS         512
// mac clock 20 MHz: slot time = 512 bit times
`define PFC_CLK_HZ            20000000
`define PFC_BITRATE_10M       10000000
`define PFC_BITRATE_100M      100000000
// slot length in mac clocks; written out because the product overflows 32-bit integer math
// 100 Mb/s truncates 102.4 to 102, so a slot runs a little short at that speed
`define PFC_SLOT_CYC_10M      12'h400
`define PFC_SLOT_CYC_100M     12'h066
// interrupt bits: 0 pause frame accepted, 1 pause interval ended
`define PFC_IRQ_W             2
`define PFC_RESP_OKAY         2'b00
`define PFC_RESP_SLVERR       2'b10
`endif

// [pfc_pause_ctrl_chk.sv]
// port assertions for the pause flow-control block
`timescale 1ns/100ps
module pfc_pause_ctrl_chk (
    input wire        i_mclk,
    input wire        i_resetn,
    input wire        i_rx_pause_valid,
    input wire        i_awvalid,
    input wire        i_arvalid,
    input wire [7:0]  i_araddr,
    input wire        i_bready,
    input wire        i_rready,
    input wire        o_awready,
    input wire        o_arready,
    input wire        o_bvalid,
    input wire        o_rvalid,
    input wire [31:0] o_rdata,
    input wire        o_tx_hold
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_resetn);
    AST_B_STANDS: assert property (o_bvalid && !i_bready |=> o_bvalid) else $error("bvalid dropped");
    AST_R_STANDS: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("rdata moved");
    AST_R_ONCE: assert property (o_rvalid && i_rready |=> !o_rvalid) else $error("second rvalid");
    AST_AR_ANSWER: assert property (i_arvalid && o_arready |=> o_rvalid) else $error("read not answered");
    AST_AW_BLOCK: assert property (o_bvalid |-> !o_awready) else $error("aw taken early");
    // a slot is at least 102 cycles, so a started pause cannot end within 8 without a new cause
    AST_HOLD_SPAN: assert property ($rose(o_tx_hold) ##1 (!i_rx_pause_valid && !i_awvalid)[*8] |-> o_tx_hold)
        else $error("pause ended early");
    AST_HOLD_CAUSE: assert property ($rose(o_tx_hold) |-> $past(i_rx_pause_valid) || $rose(o_bvalid))
        else $error("pause without cause");
    AST_CSR_READ: assert property ($rose(o_rvalid) && $past(i_araddr) == 8'h44 |-> o_rdata[28:24] == 5'h00
        && o_rdata[20:16] == 5'h00 && o_rdata[23] == $past(o_tx_hold) && (o_rdata[23] || !o_rdata[22])
        && o_rdata[23] == (o_rdata[15:0] != 16'h0000)) else $error("bad csr read");
endmodule // pfc_pause_ctrl_chk
bind pfc_pause_ctrl pfc_pause_ctrl_chk pfc_pause_ctrl_chk_i (.i_mclk(i_mclk), .i_resetn(i_resetn),
    .i_rx_pause_valid(i_rx_pause_valid), .i_awvalid(i_awvalid), .i_arvalid(i_arvalid), .i_araddr(i_araddr),
    .i_bready(i_bready), .i_rready(i_rready), .o_awready(o_awready), .o_arready(o_arready),
    .o_bvalid(o_bvalid), .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_tx_hold(o_tx_hold));

// [pfc_link_peer.sv]
// remote station model delivering parsed pause frames
`timescale 1ns/100ps
module pfc_link_peer (
    input  wire        i_mclk,
    output reg         o_valid = 1'b0,
    output reg  [47:0] o_dest = 48'h0,
    output reg         o_perfect = 1'b0,
    output reg         o_pattern = 1'b0,
    output reg  [15:0] o_len = 16'h0
);
    task send(input [47:0] d, input ph, input pt, input [15:0] n);
        begin
            @(posedge i_mclk);
            o_valid <= 1'b1;
            o_dest <= d;
            o_perfect <= ph;
            o_pattern <= pt;
            o_len <= n;
            @(posedge i_mclk);
            o_valid <= 1'b0;
            // stale fields are inverted so a late sample cannot pass by luck
            o_dest <= ~d;
            o_perfect <= ~ph;
            o_pattern <= ~pt;
            o_len <= ~n;
        end
    endtask
endmodule // pfc_link_peer

// [pfc_pause_ctrl_tb.sv]
// testbench for the pause flow-control block
`timescale 1ns/100ps
module pfc_pause_ctrl_tb;
    localparam [47:0] GRP = 48'h0180c2000001;
    reg         i_mclk = 0, i_resetn = 0, i_adv_pause_cap = 0, i_an_pause_ok = 0, i_speed_100 = 1;
    reg         i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
    reg  [7:0]  i_awaddr = 0, i_araddr = 0;
    reg  [31:0] i_wdata = 0;
    wire        o_tx_hold, o_irq, o_awready, o_wready, o_bvalid, o_arready, o_rvalid, vld, phit, qhit;
    wire [47:0] dest;
    wire [15:0] len;
    wire [1:0]  o_bresp, o_rresp;
    wire [31:0] o_rdata;
    integer     error_cnt = 0, n_checks = 0;
    always #25 i_mclk = ~i_mclk;
    pfc_link_peer pfc_link_peer_i (.i_mclk(i_mclk), .o_valid(vld), .o_dest(dest), .o_perfect(phit),
        .o_pattern(qhit), .o_len(len));
    pfc_pause_ctrl pfc_pause_ctrl_i (.i_mclk(i_mclk), .i_resetn(i_resetn), .i_speed_100(i_speed_100),
        .i_adv_pause_cap(i_adv_pause_cap), .i_an_pause_ok(i_an_pause_ok), .i_rx_pause_valid(vld),
        .i_rx_pause_dest(dest), .i_rx_perfect_hit(phit), .i_rx_pattern_hit(qhit), .i_rx_pause_len(len),
        .o_tx_hold(o_tx_hold), .o_irq(o_irq), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_wdata(i_wdata), .i_wstrb(4'hf), .i_wvalid(i_wvalid), .o_wready(o_wready), .o_bresp(o_bresp),
        .o_bvalid(o_bvalid), .i_bready(i_bready), .i_araddr(i_araddr), .i_arvalid(i_arvalid),
        .o_arready(o_arready), .o_rdata(o_rdata), .o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready));
    task chk(input [39:0] nm, input [31:0] exp, input [31:0] got);
        begin
            n_checks = n_checks + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
            end
        end
    endtask
    // one bus access; for reads d is the expected data
    task acc(input w, input [7:0] a, input [31:0] d, input [1:0] er);
        reg        ta, tw, tr, done;
        reg [31:0] dv;
        reg [1:0]  rs;
        integer    n;
        begin
            @(posedge i_mclk);
            i_awaddr <= a;
            i_araddr <= a;
            i_wdata <= d;
            i_awvalid <= w;
            i_wvalid <= w;
            i_bready <= w;
            i_arvalid <= !w;
            i_rready <= !w;
            done = 0;
            // sample at the falling edge so the rising-edge decision never races the design
            for (n = 0; n < 50 && !done; n = n + 1) begin
                @(negedge i_mclk);
                ta = i_awvalid & o_awready;
                tw = i_wvalid & o_wready;
                tr = i_arvalid & o_arready;
                done = w ? o_bvalid : o_rvalid;
                dv = o_rdata;
                rs = w ? o_bresp : o_rresp;
                @(posedge i_mclk);
                if (ta) i_awvalid <= 0;
                if (tw) i_wvalid <= 0;
                if (tr) i_arvalid <= 0;
            end
            i_bready <= 0;
            i_rready <= 0;
            chk("done", 1, done);
            chk("resp", er, rs);
            if (!w) chk("rdata", d, dv);
        end
    endtask
    task wrap_up;
        begin
            if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge i_mclk);
        i_resetn <= 1;
        acc(0, 8'h44, 32'h0, 0);
        acc(1, 8'h44, 32'hff7f0003, 0);
        acc(0, 8'h44, 32'he0800003, 0);
        acc(1, 8'h44, 32'he0010009, 0);
        acc(0, 8'h44, 32'he0800003, 0);
        repeat (408) @(posedge i_mclk);
        acc(0, 8'h44, 32'he0000000, 0);
        acc(1, 8'h4c, 32'h1, 0);
        pfc_link_peer_i.send(GRP, 0, 0, 16'h2);
        acc(0, 8'h44, 32'he0c00002, 0);
        chk("irq", 1, o_irq);
        acc(1, 8'h48, 32'h1, 0);
        chk("irq", 0, o_irq);
        acc(1, 8'h44, 32'h60000000, 0);
        acc(0, 8'h44, 32'h60000000, 0);
        pfc_link_peer_i.send(GRP, 0, 0, 16'h2);
        acc(0, 8'h44, 32'h60000000, 0);
        acc(1, 8'h44, 32'ha0000000, 0);
        pfc_link_peer_i.send(GRP, 0, 0, 16'h4);
        acc(0, 8'h44, 32'ha0000000, 0);
        pfc_link_peer_i.send(48'h0a0b0c0d0e0f, 1, 0, 16'h1);
        acc(0, 8'h44, 32'ha0c00001, 0);
        pfc_link_peer_i.send(48'h0a0b0c0d0e0f, 0, 1, 16'h5);
        acc(0, 8'h44, 32'ha0c00005, 0);
        acc(1, 8'h44, 32'h0, 0);
        chk("hold", 0, o_tx_hold);
        i_an_pause_ok <= 1;
        repeat (4) @(posedge i_mclk);
        acc(0, 8'h44, 32'h0, 0);
        i_adv_pause_cap <= 1;
        repeat (4) @(posedge i_mclk);
        acc(0, 8'h44, 32'h00200000, 0);
        acc(1, 8'h44, 32'h40000000, 0);
        pfc_link_peer_i.send(GRP, 0, 0, 16'h1);
        acc(0, 8'h44, 32'h40e00001, 0);
        acc(1, 8'h44, 32'h0, 0);
        chk("hold", 1, o_tx_hold);
        i_speed_100 <= 0;
        repeat (1100) @(posedge i_mclk);
        acc(1, 8'h44, 32'h00010001, 0);
        repeat (600) @(posedge i_mclk);
        acc(0, 8'h44, 32'h00a00001, 0);
        repeat (500) @(posedge i_mclk);
        acc(0, 8'h44, 32'h00200000, 0);
        acc(1, 8'h50, 32'hffffffff, 2'b10);
        acc(0, 8'h50, 32'h0, 2'b10);
        wrap_up;
    end
    initial begin
        #(50 * 6000);
        error_cnt = error_cnt + 1;
        wrap_up;
    end
endmodule // pfc_pause_ctrl_tb
